// >>> hw/ssi_consts.svh
`ifndef SSI_CONSTS_SVH
`define SSI_CONSTS_SVH

// Register byte offsets
`define SSI_OFF_CTRL 12'h000
`define SSI_OFF_STATUS 12'h004
`define SSI_OFF_IRQ_STAT 12'h008
`define SSI_OFF_IRQ_MASK 12'h00C

// Control register fields
`define SSI_CTRL_SCAN_ON 0
`define SSI_CTRL_SCAN_OFF 1
`define SSI_CTRL_TX_OK 2

// Interrupt status and mask fields
`define SSI_IRQ_CALL 0
`define SSI_IRQ_ANSWER 1
`define SSI_IRQ_UNANSWERED 2
`define SSI_IRQ_RESUME 3
`define SSI_IRQ_W 4

// Reset values
`define SSI_RST_TX_OK 1'b0
`define SSI_RST_MASK 4'h0

// Timing
`define SSI_CLK_HZ 20_000_000
`define SSI_RESUME_SEC 150
`define SSI_TR_SWITCH_MS 20

`endif

// >>> hw/ssi_pkg.sv
package ssi_pkg;

  // Operating states of the signalling interface
  typedef enum logic [2:0]
  {
    SSI_IDLE,
    SSI_SCAN,
    SSI_HOLD,
    SSI_CALLED,
    SSI_WAIT
  } ssi_state_t;

  typedef logic [3:0] ssi_irq_t;

endpackage

// >>> hw/ssi_top.sv
// Summary of operation
// - Mute request high keeps speaker silent, except during a call for us
// - Outside scan, external push-to-talk keys transmitter
// - Scan mode drives scan output high
// - Scan with mute: mute, lamp, eight channels
// - Scan push-to-talk holds channel, no keying
// - Scan alarm low keys transmitter for revertive
// - Call stops scan, lights called and point
// - Prompt mic push-to-talk leaves scan, clears lamps
// - Unanswered: remute, resume after 2.5 minutes
// - Transmit switching via interface within 20ms
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ssi_consts.svh"

module ssi_top #(
  // Resume delay in clocks; shorten for simulation
  parameter logic [31:0] RESUME_CYCLES =
    32'(64'(`SSI_RESUME_SEC) * 64'(`SSI_CLK_HZ))
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic quiet_req_pin,
  input wire logic ext_ptt_n_pin,
  input wire logic alarm_n_pin,
  input wire logic mic_ptt_n_pin,
  output logic scan_mode_out,
  output logic spk_mute,
  output logic scall_mute_lamp,
  output logic scan_limit8,
  output logic scan_run,
  output logic tx_key,
  output logic called_lamp,
  output logic dp_lamp,
  output logic irq
);
  import ssi_pkg::*;

  // Synchroniser stages, first and second
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  // Synchronised pin levels
  logic quiet_s;
  logic ext_ptt_s;
  logic alarm_s;
  logic mic_ptt_s;

  // Main state and its next value
  ssi_state_t state_q;
  ssi_state_t state_d;
  // Latched called indication
  logic called_q;
  // Resume countdown
  logic [31:0] resume_cnt_q;
  logic resume_done;

  // Software control
  logic tx_ok_q;
  logic scan_on_pulse;
  logic scan_off_pulse;
  ssi_irq_t irq_stat_q;
  ssi_irq_t irq_mask_q;
  ssi_irq_t events;

  // Bus decode
  logic wr_en;
  logic rd_setup;
  logic addr_ok;

  // True when a byte address maps to a register
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `SSI_OFF_CTRL) || (a == `SSI_OFF_STATUS) ||
      (a == `SSI_OFF_IRQ_STAT) || (a == `SSI_OFF_IRQ_MASK);
  endfunction

  // Two flops per pin before anything reads it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Idle levels: muted, all active-low lines released
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end
    else
    begin
      sync1_q <= {quiet_req_pin, ext_ptt_n_pin, alarm_n_pin,
        mic_ptt_n_pin};
      sync2_q <= sync1_q;
    end
  end

  // Active-high views of the synchronised lines
  assign quiet_s = sync2_q[3];
  assign ext_ptt_s = !sync2_q[2];
  assign alarm_s = !sync2_q[1];
  assign mic_ptt_s = !sync2_q[0];

  // APB handshake: access phase always completes in one cycle
  assign rd_setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign addr_ok = addr_hit(paddr);
  assign scan_on_pulse = wr_en && (paddr == `SSI_OFF_CTRL) &&
    pwdata[`SSI_CTRL_SCAN_ON];
  assign scan_off_pulse = wr_en && (paddr == `SSI_OFF_CTRL) &&
    pwdata[`SSI_CTRL_SCAN_OFF];

  // Ready and error are registered during the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= rd_setup;
      pslverr <= rd_setup && !addr_ok;
    end
  end

  // Read data captured at setup, so it is stable through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup && !pwrite)
    begin
      if (paddr == `SSI_OFF_CTRL)
        prdata <= {29'h0000_0000, tx_ok_q, 2'b00};
      else if (paddr == `SSI_OFF_STATUS)
        prdata <= {20'h0_0000, quiet_s, ext_ptt_s, alarm_s, mic_ptt_s,
          called_q, 4'h0, 3'(state_q)};
      else if (paddr == `SSI_OFF_IRQ_STAT)
        prdata <= {28'h000_0000, irq_stat_q};
      else if (paddr == `SSI_OFF_IRQ_MASK)
        prdata <= {28'h000_0000, irq_mask_q};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Transmit permission stands in for the other keying conditions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_ok_q <= `SSI_RST_TX_OK;
    else if (wr_en && paddr == `SSI_OFF_CTRL)
      tx_ok_q <= pwdata[`SSI_CTRL_TX_OK];
  end

  // Interrupt mask register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_q <= `SSI_RST_MASK;
    else if (wr_en && paddr == `SSI_OFF_IRQ_MASK)
      irq_mask_q <= pwdata[3:0];
  end

  // State transition events feed the sticky status
  always_comb
  begin
    events = 4'h0;
    events[`SSI_IRQ_CALL] = (state_q != SSI_CALLED) &&
      (state_d == SSI_CALLED);
    events[`SSI_IRQ_ANSWER] = (state_q == SSI_CALLED) &&
      (state_d == SSI_IDLE);
    events[`SSI_IRQ_UNANSWERED] = (state_q == SSI_CALLED) &&
      (state_d == SSI_WAIT);
    events[`SSI_IRQ_RESUME] = (state_q == SSI_WAIT) &&
      (state_d == SSI_SCAN);
  end

  // Sticky status cleared by a completed read; a new event wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= 4'h0;
    else if (psel && penable && pready && !pwrite &&
      paddr == `SSI_OFF_IRQ_STAT)
      irq_stat_q <= events;
    else
      irq_stat_q <= irq_stat_q | events;
  end

  // Level interrupt from any unmasked pending bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_mask_q);
  end

  assign resume_done = (resume_cnt_q == 32'h0000_0000);

  // Next state of the scan and call sequence
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SSI_IDLE:
      begin
        // Scan stays off until the scan pad is pressed again
        if (scan_on_pulse)
          state_d = SSI_SCAN;
      end
      SSI_SCAN:
      begin
        // Integrated alarm low means a call for us; also halts
        // teletype scanning
        if (scan_off_pulse)
          state_d = SSI_IDLE;
        else if (alarm_s)
          state_d = SSI_CALLED;
        else if (ext_ptt_s)
          state_d = SSI_HOLD;
      end
      SSI_HOLD:
      begin
        // Dwell while the far unit decodes the call
        if (scan_off_pulse)
          state_d = SSI_IDLE;
        else if (alarm_s)
          state_d = SSI_CALLED;
        else if (!ext_ptt_s)
          state_d = SSI_SCAN;
      end
      SSI_CALLED:
      begin
        // Prompt answer leaves scan; otherwise wait for alarm end
        if (mic_ptt_s)
          state_d = SSI_IDLE;
        else if (!alarm_s)
          state_d = SSI_WAIT;
      end
      SSI_WAIT:
      begin
        // Muted hold-off before scanning restarts
        if (mic_ptt_s || scan_off_pulse)
          state_d = SSI_IDLE;
        else if (alarm_s)
          state_d = SSI_CALLED;
        else if (resume_done)
          state_d = SSI_SCAN;
      end
      default:
        state_d = SSI_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= SSI_IDLE;
    else
      state_q <= state_d;
  end

  // Resume timer reloads on every clock outside the wait, counts down inside it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      resume_cnt_q <= 32'h0000_0000;
    else if (state_q != SSI_WAIT)
      resume_cnt_q <= RESUME_CYCLES - 32'h0000_0001;
    else if (!resume_done)
      resume_cnt_q <= resume_cnt_q - 32'h0000_0001;
  end

  // Called indication lasts until the operator keys the microphone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      called_q <= 1'b0;
    else if (state_d == SSI_CALLED)
      called_q <= 1'b1;
    else if (mic_ptt_s)
      called_q <= 1'b0;
  end

  // Lamp outputs follow the latched indication
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      called_lamp <= 1'b0;
      dp_lamp <= 1'b0;
    end
    else
    begin
      called_lamp <= called_q;
      dp_lamp <= called_q;
    end
  end

  // Scan line and scan restriction outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scan_mode_out <= 1'b0;
      scall_mute_lamp <= 1'b0;
      scan_limit8 <= 1'b0;
      scan_run <= 1'b0;
    end
    else
    begin
      scan_mode_out <= (state_q != SSI_IDLE);
      scall_mute_lamp <= (state_q != SSI_IDLE) && quiet_s;
      scan_limit8 <= (state_q != SSI_IDLE) && quiet_s;
      // Channel stepping only in the free-running scan state
      scan_run <= (state_q == SSI_SCAN);
    end
  end

  // Speaker mute: open during a call for us, shut in the wait, else follows the mute request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      spk_mute <= 1'b1;
    else if (state_q == SSI_CALLED)
      spk_mute <= 1'b0;
    else if (state_q == SSI_WAIT)
      spk_mute <= 1'b1;
    else
      spk_mute <= quiet_s;
  end

  // Transmit keying; a few clocks, far inside the switching budget
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_key <= 1'b0;
    else if (state_q == SSI_IDLE)
      tx_key <= ext_ptt_s && tx_ok_q;
    else if (state_q == SSI_CALLED)
      tx_key <= alarm_s && tx_ok_q;
    else
      tx_key <= 1'b0;
  end

endmodule // ssi_top

// >>> sim/ssi_top_props.sv
`timescale 1ns/1ps
module ssi_props
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic quiet_req_pin,
  input wire logic ext_ptt_n_pin,
  input wire logic alarm_n_pin,
  input wire logic mic_ptt_n_pin,
  input wire logic scan_mode_out,
  input wire logic spk_mute,
  input wire logic scall_mute_lamp,
  input wire logic scan_limit8,
  input wire logic scan_run,
  input wire logic tx_key,
  input wire logic called_lamp,
  input wire logic dp_lamp
);
  // Edges since reset; pin history is trusted only once it is full
  logic [2:0] up_q;
  logic ok;
  assign ok = (up_q == 3'h7);
  // Saturating count, so it never wraps into a false start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      up_q <= 3'h0;
    else if (!ok)
      up_q <= up_q + 3'h1;
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Pins reach outputs three edges late, through the synchroniser
  mute_follow_a: assert property (
    ok && $past(quiet_req_pin, 3) && $past(alarm_n_pin, 3)
    && $past(alarm_n_pin, 4) |-> spk_mute)
    else $error("speaker open while mute requested");
  scan_out_a: assert property (scan_run |-> scan_mode_out)
    else $error("scanning without scan output");
  limit_lamp_a: assert property (scan_limit8 == scall_mute_lamp)
    else $error("channel limit and mute lamp differ");
  lamp_scan_a: assert property (scall_mute_lamp |-> scan_mode_out)
    else $error("mute lamp outside scan");
  // One step may slip through when the wait resumes into a held line
  hold_scan_a: assert property (
    ok && !$past(ext_ptt_n_pin, 3) && !$past(ext_ptt_n_pin, 4)
    |-> !scan_run || !$past(scan_run))
    else $error("scan kept stepping with line held");
  tx_noscan_a: assert property (tx_key |-> !scan_run)
    else $error("keyed while scanning");
  ext_key_a: assert property (
    ok && tx_key && !scan_mode_out |-> !$past(ext_ptt_n_pin, 3))
    else $error("idle keying without external request");
  alarm_key_a: assert property (
    ok && tx_key && scan_mode_out |-> !$past(alarm_n_pin, 3))
    else $error("scan keying without alarm");
  call_stop_a: assert property (
    ok && scan_mode_out && !$past(alarm_n_pin, 3)
    && !$past(alarm_n_pin, 4) |-> !scan_run && called_lamp && !spk_mute)
    else $error("call did not stop scan or light lamp");
  dp_pair_a: assert property (called_lamp == dp_lamp)
    else $error("called lamp and point differ");
  mic_clear_a: assert property (
    ok && !$past(mic_ptt_n_pin, 3) && !$past(mic_ptt_n_pin, 4)
    |-> !called_lamp || !$past(called_lamp))
    else $error("called lamp kept after operator keyed");
  cover property (scan_run && scall_mute_lamp);
  cover property (tx_key && called_lamp);
  cover property ($fell(called_lamp));
endmodule // ssi_props

bind ssi_top ssi_props chk (
  .pclk(pclk),
  .presetn(presetn),
  .quiet_req_pin(quiet_req_pin),
  .ext_ptt_n_pin(ext_ptt_n_pin),
  .alarm_n_pin(alarm_n_pin),
  .mic_ptt_n_pin(mic_ptt_n_pin),
  .scan_mode_out(scan_mode_out),
  .spk_mute(spk_mute),
  .scall_mute_lamp(scall_mute_lamp),
  .scan_limit8(scan_limit8),
  .scan_run(scan_run),
  .tx_key(tx_key),
  .called_lamp(called_lamp),
  .dp_lamp(dp_lamp)
);

// >>> sim/ssi_far_unit.sv
`timescale 1ns/1ps
module ssi_far_unit
(
  input wire logic pclk,
  input wire logic detect, // A call is being decoded
  input wire logic ours, // The decoded call is for this station
  output logic quiet_req_pin = 1'b1,
  output logic ext_ptt_n_pin = 1'b1,
  output logic alarm_n_pin = 1'b1
);
  // Lines move only after an edge, as a clocked controller would
  always @(posedge pclk)
  begin
    quiet_req_pin <= !ours;
    ext_ptt_n_pin <= !detect;
    alarm_n_pin <= !ours;
  end
endmodule // ssi_far_unit

// >>> sim/ssi_top_tb_top.sv
`timescale 1ns/1ps
`include "ssi_consts.svh"
module ssi_top_tb_top;
  localparam int RES = 20; // Short resume delay keeps the run brief
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic mic_ptt_n_pin = 1'b1;
  logic detect = 1'b0;
  logic ours = 1'b0;
  logic [31:0] prdata, rd, m;
  logic pready, pslverr, er, irq, quiet_req_pin, ext_ptt_n_pin;
  logic alarm_n_pin, scan_mode_out, spk_mute, scall_mute_lamp;
  logic scan_limit8, scan_run, tx_key, called_lamp, dp_lamp;
  int error_cnt = 0;
  int tests_run = 0;
  int seed = 33096;
  int n;

  always #25 pclk = ~pclk;

  ssi_top #(.RESUME_CYCLES(32'(RES))) uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .quiet_req_pin(quiet_req_pin),
    .ext_ptt_n_pin(ext_ptt_n_pin),
    .alarm_n_pin(alarm_n_pin),
    .mic_ptt_n_pin(mic_ptt_n_pin),
    .scan_mode_out(scan_mode_out),
    .spk_mute(spk_mute),
    .scall_mute_lamp(scall_mute_lamp),
    .scan_limit8(scan_limit8),
    .scan_run(scan_run),
    .tx_key(tx_key),
    .called_lamp(called_lamp),
    .dp_lamp(dp_lamp),
    .irq(irq)
  );
  ssi_far_unit far (
    .pclk(pclk),
    .detect(detect),
    .ours(ours),
    .quiet_req_pin(quiet_req_pin),
    .ext_ptt_n_pin(ext_ptt_n_pin),
    .alarm_n_pin(alarm_n_pin)
  );

  task automatic results;
  begin
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
  begin
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  // One APB transfer; pready is sampled at the rising edge it completes
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int k;
  begin
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      results();
    end
    // Answer taken at the completing edge, then the request is released
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  // Expected {scan, run, mute, key, called, mute lamp} after settling
  task automatic outs(input logic [5:0] e);
  begin
    repeat (6) @(posedge pclk);
    // Channel limit follows the mute lamp, display point the called lamp
    cmp({24'h0, scan_mode_out, scan_run, spk_mute, tx_key, called_lamp,
      scall_mute_lamp, scan_limit8, dp_lamp},
      {24'h0, e, e[0], e[1]});
  end
  endtask

  // Watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (100000) @(posedge pclk);
    error_cnt++;
    results();
  end

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    outs(6'b001000);
    // Reset values, a random mask and an unmapped word
    apb(1'b0, `SSI_OFF_CTRL, 32'h0);
    cmp(rd, 32'h0);
    m = $random(seed);
    apb(1'b1, `SSI_OFF_IRQ_MASK, m);
    apb(1'b0, `SSI_OFF_IRQ_MASK, 32'h0);
    cmp(rd, m & 32'h0000_000f);
    apb(1'b1, `SSI_OFF_IRQ_MASK, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    cmp({rd[30:0], er}, 32'h1);
    // Idle keying from the external line
    apb(1'b1, `SSI_OFF_CTRL, 32'h4);
    detect <= 1'b1;
    outs(6'b001100);
    detect <= 1'b0;
    outs(6'b001000);
    // Scan, then a foreign call holds the channel
    apb(1'b1, `SSI_OFF_CTRL, 32'h5);
    outs(6'b111001);
    detect <= 1'b1;
    outs(6'b101001);
    detect <= 1'b0;
    outs(6'b111001);
    // Our call: alarm keys, masked then unmasked interrupt
    detect <= 1'b1;
    ours <= 1'b1;
    outs(6'b100110);
    cmp({31'h0, irq}, 32'h0);
    apb(1'b1, `SSI_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h1);
    apb(1'b0, `SSI_OFF_IRQ_STAT, 32'h0);
    cmp(rd, 32'h1);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h0);
    // Unanswered: remute, timed resume, lamps kept
    detect <= 1'b0;
    ours <= 1'b0;
    outs(6'b101011);
    n = 6;
    while (scan_run !== 1'b1 && n < RES + 40)
    begin
      @(posedge pclk);
      n++;
    end
    cmp({31'h0, n >= RES && n <= RES + 6}, 32'h1);
    outs(6'b111011);
    apb(1'b0, `SSI_OFF_IRQ_STAT, 32'h0);
    cmp(rd, 32'h0000_000c);
    // Answered call: operator key leaves scan, lamps out
    detect <= 1'b1;
    ours <= 1'b1;
    outs(6'b100110);
    mic_ptt_n_pin <= 1'b0;
    outs(6'b000100);
    mic_ptt_n_pin <= 1'b1;
    detect <= 1'b0;
    ours <= 1'b0;
    outs(6'b001000);
    apb(1'b0, `SSI_OFF_IRQ_STAT, 32'h0);
    cmp(rd, 32'h0000_0003);
    // Scan cancel from the control word
    apb(1'b1, `SSI_OFF_CTRL, 32'h5);
    apb(1'b1, `SSI_OFF_CTRL, 32'h6);
    outs(6'b001000);
    results();
  end
endmodule // ssi_top_tb_top
